// *** brp_agents.sv ***
`timescale 1ns/1ps
`default_nettype none

// other bus agents: requester, snooper and a loopback of the status lines
module brp_agents (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic issue_i,
   input wire brp_pkg::brp_req_t issue_req_i,
   input wire brp_pkg::brp_snoop_t issue_snp_i,
   input wire logic busy_i,
   input wire logic [2:0] response_status_i,
   input wire logic writeback_take_i,
   output logic address_strobe_o,
   output brp_pkg::brp_req_t request_o,
   output logic snoop_valid_o,
   output brp_pkg::brp_snoop_t snoop_o,
   output logic data_bus_busy_o,
   output logic [2:0] bus_status_o
);
   import brp_pkg::*;
   logic [3:0] sv;
   logic [7:0] sp;
   logic [1:0] wb_cnt;
   // request fields are junk outside the strobe, so nothing may lean on them
   assign address_strobe_o = issue_i;
   assign request_o = issue_i ? issue_req_i : ~issue_req_i;
   // snoop results four clocks after the strobe, strictly in order
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sv <= 4'h0;
      end else begin
         sv <= {sv[2:0], issue_i};
      end
      sp <= {sp[5:0], issue_snp_i};
   end
   assign snoop_valid_o = sv[3];
   assign snoop_o = sv[3] ? sp[7:6] : ~sp[7:6];
   // snooper supplies the modified line from the response clock on
   assign data_bus_busy_o = busy_i | writeback_take_i |
                            (wb_cnt != 2'h0);
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wb_cnt <= 2'h0;
      end else if (writeback_take_i) begin
         wb_cnt <= 2'h2;
      end else if (wb_cnt != 2'h0) begin
         wb_cnt <= wb_cnt - 2'h1;
      end
   end
   // every agent sees the status lines; this one never drives them
   assign bus_status_o = response_status_i;
endmodule // brp_agents

`default_nettype wire

// *** brp_ioq.sv ***
`timescale 1ns/1ps
`default_nettype none

module brp_ioq (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic push_i,
   input wire brp_pkg::brp_req_t push_req_i,
   input wire logic snoop_valid_i,
   input wire brp_pkg::brp_snoop_t snoop_i,
   input wire logic pop_i,
   output brp_pkg::brp_entry_t head_o,
   output logic [1:0] head_age_o,
   output logic [3:0] count_o
);
   import brp_pkg::*;

   brp_entry_t ent [IOQ_DEPTH];
   logic [1:0] age [IOQ_DEPTH];
   logic [IOQ_PW-1:0] wr_ptr;
   logic [IOQ_PW-1:0] rd_ptr;
   logic [IOQ_PW-1:0] sn_ptr;
   logic do_push;
   logic do_pop;
   logic do_snoop;

   // a strobe into a full queue is dropped unless the head retires that clock; the bus depth limit prevents it
   assign do_push = push_i && (count_o != IOQ_FULL || pop_i);
   assign do_pop = pop_i && ent[rd_ptr].valid;
   assign do_snoop = snoop_valid_i && ent[sn_ptr].valid &&
                     !ent[sn_ptr].snooped;
   assign head_o = ent[rd_ptr];
   assign head_age_o = age[rd_ptr];

   // entry storage: capture, snoop result, retire
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         for (int i = 0; i < IOQ_DEPTH; i++) begin
            ent[i] <= '0;
         end
      end else begin
         if (do_pop) begin
            ent[rd_ptr].valid <= 1'b0; // [RULE20]
         end
         if (do_snoop) begin
            ent[sn_ptr].snooped <= 1'b1;
            ent[sn_ptr].snp <= snoop_i;
         end
         if (do_push) begin
            ent[wr_ptr] <= '{valid: 1'b1, req: push_req_i, snooped: 1'b0,
                             snp: '0};
         end
      end
   end

   // pointers and outstanding count
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         sn_ptr <= '0;
         count_o <= '0;
      end else begin
         wr_ptr <= wr_ptr + IOQ_PW'(do_push);
         rd_ptr <= rd_ptr + IOQ_PW'(do_pop);
         sn_ptr <= sn_ptr + IOQ_PW'(do_snoop);
         count_o <= count_o + 4'(do_push) - 4'(do_pop); // [RULE20]
      end
   end

   // per-entry age since its address strobe, saturating
   for (genvar g = 0; g < IOQ_DEPTH; g++) begin : g_age
      always_ff @(posedge mclk_i) begin
         if (rst_i) begin
            age[g] <= CNT_SAT;
         end else if (do_push && wr_ptr == IOQ_PW'(g)) begin
            age[g] <= AGE_AT_PUSH;
         end else if (age[g] != CNT_SAT) begin
            age[g] <= age[g] + 2'h1;
         end
      end
   end

endmodule // brp_ioq

`default_nettype wire

// *** brp_pkg.sv ***
package brp_pkg;

   // response status codes, all-inactive pattern reserved for idle
   localparam logic [2:0] RS_IDLE = 3'h0;
   localparam logic [2:0] RS_RETRY = 3'h1;
   localparam logic [2:0] RS_POSTPONE_SNOOP = 3'h2;
   localparam logic [2:0] RS_HARD = 3'h3;
   localparam logic [2:0] RS_NODATA = 3'h4;
   localparam logic [2:0] RS_IWB = 3'h5;
   localparam logic [2:0] RS_NORMAL = 3'h6;

   // in-order queue geometry
   localparam int IOQ_DEPTH = 8;
   localparam int IOQ_PW = 3;
   localparam logic [3:0] IOQ_FULL = 4'h8;

   // spacing figures in clocks; the counters that meet them saturate at 3
   localparam logic [1:0] ADS_TARGET_READY_CLKS = 2'h3;
   localparam logic [1:0] TARGET_READY_AFTER_RESP_CLKS = 2'h1;
   localparam logic [1:0] RESP_GAP_CLKS = 2'h3;
   localparam logic [1:0] RELEASE_GAP_CLKS = 2'h3;
   localparam logic [1:0] CNT_SAT = 2'h3;
   // a new entry's age counts the strobe clock and the capture clock
   localparam logic [1:0] AGE_AT_PUSH = 2'h2;
   localparam logic [1:0] CNT_START = 2'h1;

   typedef struct packed {
      logic write;
      logic read;
      logic postpone_enable;
   } brp_req_t;

   typedef struct packed {
      logic modified_hit;
      logic postpone_snoop;
   } brp_snoop_t;

   typedef struct packed {
      logic valid;
      brp_req_t req;
      logic snooped;
      brp_snoop_t snp;
   } brp_entry_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'h0,
      S_WTRDY = 2'h1,
      S_WBTRDY = 2'h3,
      S_RESP = 2'h2
   } brp_state_t;

   // a response is present whenever any status line is asserted
   function automatic logic brp_rs_active(input logic [2:0] rs);
      brp_rs_active = |rs;
   endfunction

   function automatic logic brp_rs_parity(input logic [2:0] rs);
      brp_rs_parity = ^rs;
   endfunction

endpackage

// *** brp_resp.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE1 - writeback response one clock after ready seen with bus free
// RULE2 - writeback take strobe coincides with writeback response on the lines
// RULE3 - write with modified hit: ready twice, first dropped after handshake
// RULE4 - write ready only for writes, 3 clocks after strobe, after response
// RULE5 - writeback ready only on modified hit, after response, after a gap
// RULE6 - ready released once handshake observed for one clock
// RULE7 - one-clock release if bus free at assertion and 3 clocks spacing
// RULE8 - release may wait until response; this design releases write ready earlier and writeback ready with the response
// RULE9 - hard failure legal for any transaction, tells requester to recover
// RULE10 - modified hit forces writeback response, accepting the line
// RULE11 - deferred only with postpone enable and postpone without hit
// RULE12 - retry only when postpone asserted without modified hit
// RULE13 - read without hit or postpone gets normal data, with read data
// RULE14 - no data transaction without hit or postpone gets no data response
// RULE15 - status and parity active one clock, idle the next
// RULE16 - response after snoop, at least three clocks after previous response
// RULE17 - response waits for write release or writeback handshake
// RULE18 - normal data response only while data bus free
// RULE19 - data-less responses ignore data bus busy
// RULE20 - observed response retires head entry and lowers outstanding count
// RULE21 - status idle until driven; any active line marks a response
// RULE22 - ready asserted only for write or writeback data
// RULE23 - fixed code table on three lines, zero pattern is idle
module brp_resp (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic address_strobe_i,
   input wire brp_pkg::brp_req_t request_i,
   input wire logic snoop_valid_i,
   input wire brp_pkg::brp_snoop_t snoop_i,
   input wire logic data_bus_busy_i,
   input wire logic [2:0] bus_status_i,
   input wire logic write_ready_i,
   input wire logic writeback_ready_i,
   input wire logic hard_fail_i,
   input wire logic postpone_snoop_pick_i,
   output logic target_ready_o,
   output logic [2:0] response_status_o,
   output logic response_parity_o,
   output logic read_data_start_o,
   output logic writeback_take_o,
   output logic deferred_owed_o,
   output logic [3:0] outstanding_o
);
   import brp_pkg::*;

   brp_state_t state;
   brp_state_t next_state;
   brp_entry_t head;
   logic [1:0] head_age;
   logic [1:0] resp_gap;
   logic [1:0] rel_gap;
   logic wr_done;
   logic first_clk;
   logic hs_seen;
   logic pop;
   logic hs;
   logic head_ok;
   logic need_wr;
   logic snp_ok;
   logic start_wr;
   logic start_wb;
   logic wr_release;
   logic wb_done;
   logic start_resp;
   logic issue;
   logic [2:0] sel_code;
   logic [2:0] next_code;

   // observed response from any agent retires the head entry
   assign pop = brp_rs_active(bus_status_i); // [RULE21] [RULE20]

   brp_ioq u_ioq (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .push_i(address_strobe_i),
      .push_req_i(request_i),
      .snoop_valid_i(snoop_valid_i),
      .snoop_i(snoop_i),
      .pop_i(pop),
      .head_o(head),
      .head_age_o(head_age),
      .count_o(outstanding_o)
   );

   // handshake as every agent samples it this clock
   assign hs = target_ready_o && !data_bus_busy_i;
   assign head_ok = head.valid && state == S_IDLE &&
                    !brp_rs_active(response_status_o);
   assign need_wr = head.req.write && !wr_done; // [RULE3]
   assign snp_ok = head_ok && !need_wr && head.snooped; // [RULE16]

   // write ready: writes only, strobe spacing, after previous response
   assign start_wr = head_ok && need_wr && write_ready_i &&
                     head_age >= ADS_TARGET_READY_CLKS &&
                     resp_gap >= TARGET_READY_AFTER_RESP_CLKS; // [RULE4] [RULE22]

   // writeback ready needs the line low for a clock before, so a write
   // ready that was just released cannot merge into this one
   assign start_wb = snp_ok && head.snp.modified_hit && writeback_ready_i &&
                     !target_ready_o &&
                     resp_gap >= TARGET_READY_AFTER_RESP_CLKS; // [RULE5] [RULE22]

   // release after one observed handshake, or at once when spacing allows
   assign wr_release = state == S_WTRDY &&
                       (hs_seen ||
                        (hs && first_clk &&
                         rel_gap >= RELEASE_GAP_CLKS)); // [RULE6] [RULE7]
   // writeback ready falls on the same edge that drives the writeback response
   assign wb_done = state == S_WBTRDY && hs; // [RULE8] [RULE17]

   // legal response for a snooped entry without modified hit
   always_comb begin
      if (hard_fail_i) begin
         sel_code = RS_HARD; // [RULE9]
      end else if (head.snp.postpone_snoop) begin
         if (head.req.postpone_enable && postpone_snoop_pick_i) begin
            sel_code = RS_POSTPONE_SNOOP; // [RULE11]
         end else begin
            sel_code = RS_RETRY; // [RULE12]
         end
      end else if (head.req.read) begin
         sel_code = RS_NORMAL; // [RULE13]
      end else begin
         sel_code = RS_NODATA; // [RULE14]
      end
   end

   // data-less codes go out even while an earlier transfer holds the bus
   assign start_resp = snp_ok && !head.snp.modified_hit &&
                       resp_gap >= RESP_GAP_CLKS &&
                       (sel_code != RS_NORMAL ||
                        !data_bus_busy_i); // [RULE16] [RULE18] [RULE19]
   assign issue = start_resp || wb_done;
   assign next_code = wb_done ? RS_IWB : sel_code; // [RULE10] [RULE23]

   // phase sequencing
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (start_wr) begin
               next_state = S_WTRDY;
            end else if (start_wb) begin
               next_state = S_WBTRDY;
            end else if (start_resp) begin
               next_state = S_RESP;
            end
         end
         S_WTRDY: begin
            if (wr_release) begin
               next_state = S_IDLE;
            end
         end
         S_WBTRDY: begin
            if (wb_done) begin
               next_state = S_RESP;
            end
         end
         S_RESP: begin
            next_state = S_IDLE;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // target ready line
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         target_ready_o <= 1'b0;
      end else if (start_wr || start_wb) begin
         target_ready_o <= 1'b1; // [RULE4] [RULE5]
      end else if (wr_release || wb_done) begin
         target_ready_o <= 1'b0; // [RULE3] [RULE6]
      end
   end

   // handshake history of the current write ready
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         first_clk <= 1'b0;
         hs_seen <= 1'b0;
      end else begin
         first_clk <= start_wr;
         hs_seen <= state == S_WTRDY && hs && !wr_release;
      end
   end

   // write data phase done for the head; cleared as the head retires
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wr_done <= 1'b0;
      end else if (wr_release) begin
         wr_done <= 1'b1;
      end else if (pop) begin
         wr_done <= 1'b0;
      end
   end

   // clocks since own response, counting the response clock as one
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         resp_gap <= CNT_SAT;
      end else if (issue) begin
         resp_gap <= CNT_START; // [RULE16]
      end else if (resp_gap != CNT_SAT) begin
         resp_gap <= resp_gap + 2'h1;
      end
   end

   // clocks since ready fell, counting the first low clock as one
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rel_gap <= CNT_SAT;
      end else if (wr_release || wb_done) begin
         rel_gap <= CNT_START; // [RULE7]
      end else if (rel_gap != CNT_SAT) begin
         rel_gap <= rel_gap + 2'h1;
      end
   end

   // status lines and parity: one active clock, then idle
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         response_status_o <= RS_IDLE;
         response_parity_o <= 1'b0;
      end else if (issue) begin
         response_status_o <= next_code; // [RULE1] [RULE15]
         response_parity_o <= brp_rs_parity(next_code);
      end else begin
         response_status_o <= RS_IDLE; // [RULE15] [RULE21]
         response_parity_o <= 1'b0;
      end
   end

   // user strobes aligned with the response clock
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         read_data_start_o <= 1'b0;
         writeback_take_o <= 1'b0;
         deferred_owed_o <= 1'b0;
      end else begin
         read_data_start_o <= start_resp && sel_code == RS_NORMAL; // [RULE13]
         writeback_take_o <= wb_done; // [RULE2] [RULE10]
         deferred_owed_o <= start_resp && sel_code == RS_POSTPONE_SNOOP; // [RULE11]
      end
   end

   property p_iwb_timing;
      @(posedge mclk_i) disable iff (rst_i)
      (state == S_WBTRDY && target_ready_o && !data_bus_busy_i) |=>
         (response_status_o == RS_IWB && !target_ready_o);
   endproperty
   a_iwb_timing: assert property (p_iwb_timing) // [RULE1]
      else $error("writeback response not one clock after handshake");

   property p_wb_take;
      @(posedge mclk_i) disable iff (rst_i)
      (response_status_o == RS_IWB) |-> writeback_take_o;
   endproperty
   a_wb_take: assert property (p_wb_take) // [RULE2]
      else $error("writeback take not aligned with response");

   property p_one_clock;
      @(posedge mclk_i) disable iff (rst_i)
      brp_rs_active(response_status_o) |=>
         (response_status_o == RS_IDLE && !response_parity_o)[*2];
   endproperty
   a_one_clock: assert property (p_one_clock) // [RULE15]
      else $error("response held or repeated too soon");

   property p_parity;
      @(posedge mclk_i) disable iff (rst_i)
      $changed(response_status_o) |->
         response_parity_o == ^response_status_o;
   endproperty
   a_parity: assert property (p_parity) // [RULE15]
      else $error("response parity wrong");

   property p_ready_after_resp;
      @(posedge mclk_i) disable iff (rst_i)
      brp_rs_active(response_status_o) |=> !$rose(target_ready_o);
   endproperty
   a_ready_after_resp: assert property (p_ready_after_resp) // [RULE4]
      else $error("target ready in clock after response");

   property p_ready_gap;
      @(posedge mclk_i) disable iff (rst_i)
      $fell(target_ready_o) |=> !target_ready_o;
   endproperty
   a_ready_gap: assert property (p_ready_gap) // [RULE5]
      else $error("target ready reasserted without idle clock");

   property p_ready_cause;
      @(posedge mclk_i) disable iff (rst_i)
      $rose(target_ready_o) |->
         $past(head.req.write && head_age >= ADS_TARGET_READY_CLKS && !wr_done) ||
         $past(head.snooped && head.snp.modified_hit);
   endproperty
   a_ready_cause: assert property (p_ready_cause) // [RULE22]
      else $error("target ready without data to move");

   property p_normal_free;
      @(posedge mclk_i) disable iff (rst_i)
      (response_status_o == RS_NORMAL) |-> $past(!data_bus_busy_i);
   endproperty
   a_normal_free: assert property (p_normal_free) // [RULE18]
      else $error("normal data response while data bus busy");

   property p_postpone_snoop_legal;
      @(posedge mclk_i) disable iff (rst_i)
      (response_status_o == RS_POSTPONE_SNOOP) |->
         $past(head.req.postpone_enable && head.snp.postpone_snoop &&
               !head.snp.modified_hit) && deferred_owed_o;
   endproperty
   a_postpone_snoop_legal: assert property (p_postpone_snoop_legal) // [RULE11]
      else $error("deferred response not allowed here");

   property p_hit_forces_iwb;
      @(posedge mclk_i) disable iff (rst_i)
      (brp_rs_active(response_status_o) && $past(head.snp.modified_hit)) |->
         response_status_o == RS_IWB;
   endproperty
   a_hit_forces_iwb: assert property (p_hit_forces_iwb) // [RULE10]
      else $error("modified hit answered with other response");

endmodule // brp_resp

`default_nettype wire

// *** bus_response_phase_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end

module bus_response_phase_control_test;
   import brp_pkg::*;
   logic mclk_i, rst_i, iss, busy, wr_rdy, wb_rdy, hard, pick;
   brp_req_t ireq, request;
   brp_snoop_t isnp, snoop;
   logic strobe, snoop_valid, dbb, target_ready, rds, take, owed, par;
   logic [2:0] bus_status, rs;
   logic [3:0] outstanding;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int rdy_cnt = 0;
   int t0;

   brp_resp uut (.mclk_i(mclk_i), .rst_i(rst_i), .address_strobe_i(strobe),
      .request_i(request), .snoop_valid_i(snoop_valid), .snoop_i(snoop),
      .data_bus_busy_i(dbb), .bus_status_i(bus_status),
      .write_ready_i(wr_rdy), .writeback_ready_i(wb_rdy),
      .hard_fail_i(hard), .postpone_snoop_pick_i(pick), .target_ready_o(target_ready),
      .response_status_o(rs), .response_parity_o(par),
      .read_data_start_o(rds), .writeback_take_o(take),
      .deferred_owed_o(owed), .outstanding_o(outstanding));

   brp_agents agents (.mclk_i(mclk_i), .rst_i(rst_i), .issue_i(iss),
      .issue_req_i(ireq), .issue_snp_i(isnp), .busy_i(busy),
      .response_status_i(rs), .writeback_take_i(take),
      .address_strobe_o(strobe), .request_o(request),
      .snoop_valid_o(snoop_valid), .snoop_o(snoop),
      .data_bus_busy_o(dbb), .bus_status_o(bus_status));

   // clock and cycle count; ready cycles are counted to spot stray assertions
   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (target_ready === 1'b1) rdy_cnt <= rdy_cnt + 1;
   end

   task automatic conclude();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk_i);
   endtask

   // one-clock address strobe; t0 holds the strobe cycle
   task automatic send_req(input logic [2:0] r, input logic [1:0] s);
      @(posedge mclk_i);
      iss <= 1'b1;
      ireq <= brp_req_t'(r);
      isnp <= brp_snoop_t'(s);
      #1 t0 = cyc;
      @(posedge mclk_i);
      iss <= 1'b0;
      #1;
   endtask

   // bounded wait for ready (rdy=1) or for any response code (rdy=0)
   task automatic wait_on(input bit rdy, output int t);
      int i;
      t = -1;
      for (i = 0; i < 60 && t < 0; i++) begin
         @(posedge mclk_i);
         #1;
         if (rdy ? target_ready === 1'b1 : rs !== 3'h0) t = cyc;
      end
      `CHK(t >= 0, 1'b1)
   endtask

   task automatic chk_resp(input logic [2:0] code);
      int t;
      wait_on(1'b0, t);
      `CHK(rs, code)
      `CHK(par, ^code)
      `CHK(rds, code == RS_NORMAL)
      `CHK(owed, code == RS_POSTPONE_SNOOP)
      @(posedge mclk_i);
      #1;
      `CHK(rs, 3'h0)
      `CHK(par, 1'b0)
   endtask

   // a read with both receivers ready must never see target ready
   task automatic t_read();
      int n;
      n = rdy_cnt;
      wr_rdy <= 1'b1;
      wb_rdy <= 1'b1;
      send_req(3'h2, 2'h0);
      chk_resp(RS_NORMAL);
      `CHK(rdy_cnt - n, 0)
      @(posedge mclk_i);
      wr_rdy <= 1'b0;
      wb_rdy <= 1'b0;
   endtask

   // plain write: ready three clocks after strobe, released after one
   task automatic t_write();
      int t;
      @(posedge mclk_i);
      wr_rdy <= 1'b1;
      send_req(3'h4, 2'h0);
      wait_on(1'b1, t);
      `CHK(t - t0, 3)
      @(posedge mclk_i);
      #1;
      `CHK(target_ready, 1'b0)
      chk_resp(RS_NODATA);
      @(posedge mclk_i);
      wr_rdy <= 1'b0;
   endtask

   // read hitting a modified line while the data bus is busy for the first four ready clocks
   task automatic t_wb_read();
      int t;
      wb_rdy <= 1'b1;
      busy <= 1'b1;
      send_req(3'h2, 2'h3);
      wait_on(1'b1, t);
      repeat (3) begin
         @(posedge mclk_i);
         #1;
         `CHK(target_ready, 1'b1)
         `CHK(rs, 3'h0)
      end
      // bus frees in this clock; the handshake is seen at its end
      @(posedge mclk_i);
      busy <= 1'b0;
      #1;
      `CHK(target_ready, 1'b1)
      `CHK(rs, 3'h0)
      @(posedge mclk_i);
      #1;
      `CHK(rs, RS_IWB)
      `CHK(take, 1'b1)
      `CHK(target_ready, 1'b0)
      @(posedge mclk_i);
      wb_rdy <= 1'b0;
      idle(4);
   endtask

   // write hitting a modified line: ready twice with a gap between
   task automatic t_wb_write();
      int t;
      wr_rdy <= 1'b1;
      wb_rdy <= 1'b1;
      send_req(3'h4, 2'h2);
      wait_on(1'b1, t);
      `CHK(t - t0, 3)
      @(posedge mclk_i);
      #1;
      `CHK(target_ready, 1'b0)
      wait_on(1'b1, t);
      @(posedge mclk_i);
      #1;
      `CHK(rs, RS_IWB)
      `CHK(take, 1'b1)
      @(posedge mclk_i);
      wr_rdy <= 1'b0;
      wb_rdy <= 1'b0;
      idle(4);
   endtask

   // postpone with and without enable and pick
   task automatic t_postpone();
      logic [2:0] pe, pk;
      logic [2:0] code;
      pe = 3'h5;
      pk = 3'h3;
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk_i);
         pick <= pk[i];
         code = (pe[i] && pk[i]) ? RS_POSTPONE_SNOOP : RS_RETRY;
         send_req({2'h1, pe[i]}, 2'h1);
         chk_resp(code);
      end
      @(posedge mclk_i);
      pick <= 1'b0;
   endtask

   task automatic t_hard();
      hard <= 1'b1;
      send_req(3'h2, 2'h0);
      chk_resp(RS_HARD);
      @(posedge mclk_i);
      hard <= 1'b0;
   endtask

   // data-less answer goes out under busy, normal data waits for it
   task automatic t_busy();
      busy <= 1'b1;
      send_req(3'h0, 2'h0);
      chk_resp(RS_NODATA);
      send_req(3'h2, 2'h0);
      repeat (11) begin
         @(posedge mclk_i);
         #1;
         `CHK(rs, 3'h0)
      end
      @(posedge mclk_i);
      busy <= 1'b0;
      #1;
      `CHK(rs, 3'h0)
      chk_resp(RS_NORMAL);
   endtask

   // two reads two clocks apart: queue count and response spacing
   task automatic t_spacing();
      int a, b;
      send_req(3'h2, 2'h0);
      send_req(3'h2, 2'h0);
      `CHK(outstanding, 4'h2)
      wait_on(1'b0, a);
      wait_on(1'b0, b);
      `CHK(b - a >= 3, 1'b1)
      idle(3);
      #1;
      `CHK(outstanding, 4'h0)
   endtask

   initial begin
      rst_i = 1'b1;
      iss = 1'b0;
      ireq = '0;
      isnp = '0;
      busy = 1'b0;
      wr_rdy = 1'b0;
      wb_rdy = 1'b0;
      hard = 1'b0;
      pick = 1'b0;
      idle(5);
      rst_i <= 1'b0;
      t_read();
      t_write();
      t_wb_read();
      t_wb_write();
      t_postpone();
      t_hard();
      t_busy();
      t_spacing();
      idle(4);
      conclude();
   end

   // hang guard, far beyond the roughly 130 clocks the tests need
   initial begin
      idle(3000);
      fail_count++;
      conclude();
   end
endmodule // bus_response_phase_control_test

`default_nettype wire
